//--- src/nsx_pkg.sv
package nsx_pkg;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 7;
    localparam int DEST_BIT  = 7;
    localparam int OP_HI     = 13;
    localparam int OP_LO     = 8;

    // ------------------------------------------------------------------
    // Opcode patterns
    // ------------------------------------------------------------------
    localparam logic [5:0]  OPC_NIBBLE_EXCHANGE = 6'h0E;
    localparam logic [5:0]  OPC_REGISTER_XOR    = 6'h06;
    localparam logic [5:0]  OPC_IMMEDIATE_XOR   = 6'h3A;
    localparam logic [10:0] OPC_DIRECTION_LOAD  = 11'h00C;
    localparam logic [2:0]  DIR_SEL_MIN         = 3'h5;
    localparam logic [2:0]  DIR_SEL_MAX         = 3'h7;
    localparam int          DIR_COUNT           = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  WORK_RST            = 8'h00;
    localparam logic [7:0]  DIR_RST             = 8'hFF;
    localparam logic        ZERO_RST            = 1'b0;

    typedef enum logic [2:0] {
        NSX_OP_NONE,
        NSX_OP_NIBBLE_EXCHANGE,
        NSX_OP_DIRECTION_LOAD,
        NSX_OP_IMMEDIATE_XOR,
        NSX_OP_REGISTER_XOR
    } nsx_op_e;

endpackage : nsx_pkg

//--- src/nsx_dec_if.sv
`timescale 1ns/1ps
interface nsx_dec_if;
    import nsx_pkg::*;
    nsx_op_e           op;
    logic              dest_reg;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] imm;
    logic [1:0]        dir_idx;

    modport dec (output op, dest_reg, addr, imm, dir_idx);
    modport exe (input  op, dest_reg, addr, imm, dir_idx);
endinterface : nsx_dec_if

//--- src/nsx_decode.sv
`timescale 1ns/1ps
module nsx_decode
    import nsx_pkg::*;
(
    // Instruction
    input  wire logic [INSTR_W-1:0] i_instr,
    // Decoded fields
    nsx_dec_if.dec                  dec
);

    logic [2:0] dir_sel;

    assign dir_sel      = i_instr[2:0];
    assign dec.dest_reg = i_instr[DEST_BIT];
    assign dec.addr     = i_instr[ADDR_W-1:0];
    assign dec.imm      = i_instr[DATA_W-1:0];
    assign dec.dir_idx  = 2'(dir_sel - DIR_SEL_MIN);

    always_comb
    begin
        if (i_instr[OP_HI:OP_LO] == OPC_NIBBLE_EXCHANGE)
            dec.op = NSX_OP_NIBBLE_EXCHANGE;                 // [RULE_01]
        else if (i_instr[OP_HI:OP_LO] == OPC_REGISTER_XOR)
            dec.op = NSX_OP_REGISTER_XOR;                    // [RULE_06]
        else if (i_instr[OP_HI:OP_LO] == OPC_IMMEDIATE_XOR)
            dec.op = NSX_OP_IMMEDIATE_XOR;                   // [RULE_05]
        else if (i_instr[OP_HI:3] == OPC_DIRECTION_LOAD
                 && dir_sel >= DIR_SEL_MIN && dir_sel <= DIR_SEL_MAX)
            dec.op = NSX_OP_DIRECTION_LOAD;                  // [RULE_03]
        else
            dec.op = NSX_OP_NONE;
    end

endmodule : nsx_decode

//--- src/nsx_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Opcode 00 1110 swaps the two nibbles of the addressed register; no flags change.
// RULE_02 - Nibble swap result goes to working register if d=0, addressed register if d=1.
// RULE_03 - Legacy direction load copies working register to direction register 5..7; no flags.
// RULE_04 - Direction registers stay ordinary readable and writable data-memory locations.
// RULE_05 - Opcode 11 1010 XORs working register with immediate into working register; Z only.
// RULE_06 - Opcode 00 0110 XORs working register with addressed register; only Z updates.
// RULE_07 - Register XOR result to working register if d=0, addressed register if d=1.
// RULE_08 - XOR forms set Z when result is zero, else clear; each op takes one cycle.
module nsx_exec
    import nsx_pkg::*;
#(
    parameter logic [ADDR_W-1:0] DIR_BASE_ADDR = 7'h05
)
(
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_srst,
    // Instruction issue, one word per enabled cycle
    input  wire logic               i_instr_valid,
    input  wire logic [INSTR_W-1:0] i_instr,
    // Data memory read value of the addressed register
    input  wire logic [DATA_W-1:0]  i_file_rdata,
    // Ordinary data-memory writes toward direction registers
    input  wire logic               i_mem_we,
    input  wire logic [ADDR_W-1:0]  i_mem_addr,
    input  wire logic [DATA_W-1:0]  i_mem_wdata,
    // Data memory access
    output logic [ADDR_W-1:0]       o_file_addr,
    output logic                    o_file_we,
    output logic [DATA_W-1:0]       o_file_wdata,
    // Core state
    output logic [DATA_W-1:0]       o_work,
    output logic                    o_zero,
    output logic [DATA_W-1:0]       o_dir_0,
    output logic [DATA_W-1:0]       o_dir_1,
    output logic [DATA_W-1:0]       o_dir_2,
    output logic                    o_done,
    output logic                    o_illegal
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    nsx_dec_if dec_bus ();

    nsx_decode u_decode (
        .i_instr (i_instr),
        .dec     (dec_bus)
    );

    logic [DATA_W-1:0] work;
    logic              zero;
    logic [DATA_W-1:0] dir_q [DIR_COUNT];
    logic [DATA_W-1:0] next_result;
    logic              write_work;
    logic              write_file;
    logic              update_zero;
    logic              exec;

    assign exec        = i_instr_valid;
    assign o_file_addr = dec_bus.addr;

    // ------------------------------------------------------------------
    // Result and destination selection
    // ------------------------------------------------------------------
    always_comb
    begin
        next_result = work;
        write_work  = 1'b0;
        write_file  = 1'b0;
        update_zero = 1'b0;
        case (dec_bus.op)
            NSX_OP_NIBBLE_EXCHANGE:
            begin
                next_result = {i_file_rdata[3:0], i_file_rdata[7:4]}; // [RULE_01]
                write_work  = !dec_bus.dest_reg;                      // [RULE_02]
                write_file  = dec_bus.dest_reg;                       // [RULE_02]
            end
            NSX_OP_IMMEDIATE_XOR:
            begin
                next_result = work ^ dec_bus.imm;                     // [RULE_05]
                write_work  = 1'b1;
                update_zero = 1'b1;
            end
            NSX_OP_REGISTER_XOR:
            begin
                next_result = work ^ i_file_rdata;                    // [RULE_06]
                write_work  = !dec_bus.dest_reg;                      // [RULE_07]
                write_file  = dec_bus.dest_reg;                       // [RULE_07]
                update_zero = 1'b1;
            end
            default:
            begin
                next_result = work;
            end
        endcase
    end

    // The data-memory write is a plain combinational strobe with no handshake, taken in this cycle.
    assign o_file_we    = exec && write_file;
    assign o_file_wdata = next_result;

    // ------------------------------------------------------------------
    // Working register and zero flag
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            work <= WORK_RST;
        else if (exec && write_work)
            work <= next_result;                                      // [RULE_08]
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            zero <= ZERO_RST;
        else if (exec && update_zero)
            zero <= (next_result == '0);                              // [RULE_08]
    end

    // ------------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------------
    // A legacy load and an ordinary store to the same register in one
    // cycle cannot both come from one core; the legacy load wins.
    for (genvar g = 0; g < DIR_COUNT; g++)
    begin : g_dir
        always_ff @(posedge i_mclk)
        begin
            if (i_srst)
                dir_q[g] <= DIR_RST;
            else if (exec && dec_bus.op == NSX_OP_DIRECTION_LOAD
                     && dec_bus.dir_idx == 2'(g))
                dir_q[g] <= work;                                     // [RULE_03]
            else if (i_mem_we && i_mem_addr == ADDR_W'(DIR_BASE_ADDR + g))
                dir_q[g] <= i_mem_wdata;                              // [RULE_04]
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_done    <= 1'b0;
            o_illegal <= 1'b0;
        end
        else
        begin
            o_done    <= exec && dec_bus.op != NSX_OP_NONE;           // [RULE_08]
            o_illegal <= exec && dec_bus.op == NSX_OP_NONE;
        end
    end

    assign o_work  = work;
    assign o_zero  = zero;
    assign o_dir_0 = dir_q[0];
    assign o_dir_1 = dir_q[1];
    assign o_dir_2 = dir_q[2];

endmodule : nsx_exec

//--- bench/nsx_exec_props.sv
`timescale 1ns/1ps
module nsx_exec_props
    import nsx_pkg::*;
#(
    parameter logic [ADDR_W-1:0] DIR_BASE_ADDR = 7'h05
)
(
    // Inputs
    input wire logic               i_mclk,
    input wire logic               i_srst,
    input wire logic               i_instr_valid,
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic [DATA_W-1:0]  i_file_rdata,
    input wire logic               i_mem_we,
    input wire logic [ADDR_W-1:0]  i_mem_addr,
    input wire logic [DATA_W-1:0]  i_mem_wdata,
    // Outputs
    input wire logic               o_file_we,
    input wire logic [DATA_W-1:0]  o_file_wdata,
    input wire logic [DATA_W-1:0]  o_work,
    input wire logic               o_zero,
    input wire logic [DATA_W-1:0]  o_dir_0,
    input wire logic               o_done
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    sequence s_swap; i_instr_valid && i_instr[13:8] == OPC_NIBBLE_EXCHANGE; endsequence
    sequence s_rxor; i_instr_valid && i_instr[13:8] == OPC_REGISTER_XOR; endsequence
    sequence s_ixor; i_instr_valid && i_instr[13:8] == OPC_IMMEDIATE_XOR; endsequence
    sequence s_dld; i_instr_valid && i_instr == {OPC_DIRECTION_LOAD, DIR_SEL_MIN}; endsequence
    swap_data_a: assert property (s_swap |-> o_file_wdata == {i_file_rdata[3:0], i_file_rdata[7:4]})
        else $error("swap data");
    swap_flag_a: assert property (s_swap |=> $stable(o_zero)) else $error("swap flag");
    swap_dest_a: assert property (s_swap ##0 !i_instr[DEST_BIT] |-> !o_file_we
        ##1 o_work == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])}) else $error("swap dest");
    dir_load_a: assert property (s_dld |=> o_dir_0 == $past(o_work) && $stable(o_zero))
        else $error("dir load");
    dir_mem_a: assert property (!i_instr_valid && i_mem_we && i_mem_addr == DIR_BASE_ADDR
        |=> o_dir_0 == $past(i_mem_wdata)) else $error("dir write");
    imm_xor_a: assert property (s_ixor |=> o_work == ($past(o_work) ^ $past(i_instr[7:0]))
        && o_zero == (o_work == 8'h00)) else $error("imm xor");
    reg_xor_file_a: assert property (s_rxor ##0 i_instr[DEST_BIT] |-> o_file_we
        && o_file_wdata == (o_work ^ i_file_rdata)) else $error("reg xor file");
    reg_xor_work_a: assert property (s_rxor ##0 !i_instr[DEST_BIT]
        |=> o_work == ($past(o_work) ^ $past(i_file_rdata))) else $error("reg xor work");
    one_cycle_a: assert property (s_ixor or s_swap |=> o_done) else $error("done");
    reg_xor_zero_a: assert property (s_rxor |=> o_zero ==
        (($past(o_work) ^ $past(i_file_rdata)) == 8'h00)) else $error("reg xor zero");
endmodule : nsx_exec_props

bind nsx_exec nsx_exec_props #(.DIR_BASE_ADDR(DIR_BASE_ADDR)) nsx_exec_props_inst (
    .i_mclk        (i_mclk),
    .i_srst        (i_srst),
    .i_instr_valid (i_instr_valid),
    .i_instr       (i_instr),
    .i_file_rdata  (i_file_rdata),
    .i_mem_we      (i_mem_we),
    .i_mem_addr    (i_mem_addr),
    .i_mem_wdata   (i_mem_wdata),
    .o_file_we     (o_file_we),
    .o_file_wdata  (o_file_wdata),
    .o_work        (o_work),
    .o_zero        (o_zero),
    .o_dir_0       (o_dir_0),
    .o_done        (o_done)
);

//--- bench/nsx_exec_tb.sv
`timescale 1ns/1ps
module nsx_exec_tb;
    import nsx_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_instr_valid = 1'b0;
    logic        i_mem_we = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [7:0]  i_file_rdata = 8'h00;
    logic [6:0]  i_mem_addr = 7'h00;
    logic [7:0]  i_mem_wdata = 8'h00;
    logic [6:0]  o_file_addr, fa_s;
    logic [7:0]  o_file_wdata, o_work, o_dir_0, o_dir_1, o_dir_2, wd_s, w;
    logic        o_file_we, o_zero, o_done, o_illegal, we_s;
    int          errors = 0;
    int          num_checks = 0;
    always #20 i_mclk = ~i_mclk;
    nsx_exec nsx_exec_inst (
        .i_mclk        (i_mclk),
        .i_srst        (i_srst),
        .i_instr_valid (i_instr_valid),
        .i_instr       (i_instr),
        .i_file_rdata  (i_file_rdata),
        .i_mem_we      (i_mem_we),
        .i_mem_addr    (i_mem_addr),
        .i_mem_wdata   (i_mem_wdata),
        .o_file_addr   (o_file_addr),
        .o_file_we     (o_file_we),
        .o_file_wdata  (o_file_wdata),
        .o_work        (o_work),
        .o_zero        (o_zero),
        .o_dir_0       (o_dir_0),
        .o_dir_1       (o_dir_1),
        .o_dir_2       (o_dir_2),
        .o_done        (o_done),
        .o_illegal     (o_illegal)
    );
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // File port outputs are combinational, so they are captured before the taking edge.
    task automatic ex(input logic [13:0] wd, input logic [7:0] rd);
        @(posedge i_mclk);
        i_instr_valid <= 1'b1;
        i_instr <= wd;
        i_file_rdata <= rd;
        #1;
        we_s = o_file_we;
        wd_s = o_file_wdata;
        fa_s = o_file_addr;
        @(posedge i_mclk);
        i_instr_valid <= 1'b0;
        #1;
    endtask : ex
    task automatic t_imm;
        ex(14'h3AB5, 8'h00);
        chk("work", 8'hB5, o_work);
        ex(14'h3AAF, 8'h00);
        chk("work", 8'h1A, o_work);
        chk("zero", 8'h00, {7'h0, o_zero});
        ex(14'h3A1A, 8'h00);
        chk("zero", 8'h01, {7'h0, o_zero});
        chk("done", 8'h01, {7'h0, o_done});
        $display("imm xor test finished");
    endtask : t_imm
    task automatic t_swap;
        ex(14'h0E10, 8'hA5);
        chk("work", 8'h5A, o_work);
        chk("zero", 8'h01, {7'h0, o_zero});
        ex(14'h0E90, 8'h3C);
        chk("file_we", 8'h01, {7'h0, we_s});
        chk("wdata", 8'hC3, wd_s);
        chk("file_addr", 8'h10, {1'b0, fa_s});
        chk("work", 8'h5A, o_work);
        $display("swap test finished");
    endtask : t_swap
    task automatic t_rxor;
        ex(14'h0690, 8'h0F);
        chk("file_we", 8'h01, {7'h0, we_s});
        chk("wdata", 8'h55, wd_s);
        chk("zero", 8'h00, {7'h0, o_zero});
        ex(14'h0610, 8'h5A);
        chk("file_we", 8'h00, {7'h0, we_s});
        chk("work", 8'h00, o_work);
        chk("zero", 8'h01, {7'h0, o_zero});
        $display("reg xor test finished");
    endtask : t_rxor
    task automatic t_dir;
        w = 8'h00;
        for (int s = 5; s <= 7; s++)
        begin
            ex({6'h3A, w ^ (8'h30 + 8'(s))}, 8'h00);
            w = 8'h30 + 8'(s);
            ex({11'h00C, 3'(s)}, 8'h00);
        end
        chk("dir0", 8'h35, o_dir_0);
        chk("dir1", 8'h36, o_dir_1);
        chk("dir2", 8'h37, o_dir_2);
        ex(14'h0064, 8'h00);
        chk("illegal", 8'h01, {7'h0, o_illegal});
        chk("dir0", 8'h35, o_dir_0);
        @(posedge i_mclk);
        i_mem_we <= 1'b1;
        i_mem_addr <= 7'h06;
        i_mem_wdata <= 8'hC3;
        @(posedge i_mclk);
        i_mem_addr <= 7'h05;
        i_mem_wdata <= 8'h96;
        @(posedge i_mclk);
        i_mem_we <= 1'b0;
        #1;
        chk("dir1", 8'hC3, o_dir_1);
        chk("dir0", 8'h96, o_dir_0);
        $display("direction test finished");
    endtask : t_dir
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (5) @(posedge i_mclk);
        i_srst <= 1'b0;
        #1;
        chk("work", 8'h00, o_work);
        chk("dir2", 8'hFF, o_dir_2);
        t_imm();
        t_swap();
        t_rxor();
        t_dir();
        report_and_stop();
    end
endmodule : nsx_exec_tb
